// ===== rtl/rmcr_top.sv
// Purpose: runtime misc config registers, idx 0x20..0x23
// Assumes: classic wishbone slave, 125 MHz clk_i
// Notes:   all state in one struct, outputs from flops
// Function
// - read-only copy of serial fifo control
// - edge bit0 picks edges, pin2 sysint
// - edge bit1 picks edges, pin6 sysint
// - edge bit2 picks edges, pin2 wake
// - edge bit3 picks edges, pin6 wake
// - force-off bits override unit activate bits
// - force-off bit0 forces floppy write protect
// - write protect is OR of terms
// - force-off bits 2:1 read zero
// - bit3 disables floppy controller
// - bit5 disables midi serial unit
// - bit6 disables main serial port
// - bit7 disables parallel port
// - gpio cfg bit0: 1 input, 0 output
// - gpio cfg bit1 inverts both directions
// - gpio cfg bit2 routes pin to joystick
// - gpio cfg bit7 selects open drain
`timescale 1ns/1ps
`default_nettype none
module rmcr_top (
	// clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// wishbone classic slave
	input  wire logic                      cyc_i,
	input  wire logic                      stb_i,
	input  wire logic                      we_i,
	input  wire logic [rmcr_pkg::ADR_W-1:0] adr_i,
	input  wire logic [3:0]                sel_i,
	input  wire logic [31:0]               dat_i,
	output logic      [31:0]               dat_o,
	output logic                           ack_o,
	// serial port fifo control write
	input  wire logic                      fcr_wr_i,
	input  wire logic [7:0]                fcr_data_i,
	// keyboard controller port pins
	input  wire logic                      kbc_port1_bit2_i,
	input  wire logic                      kbc_port1_bit6_i,
	// status set pulses
	output logic                           sysint_pin2_set_o,
	output logic                           sysint_pin6_set_o,
	output logic                           wake_pin2_set_o,
	output logic                           wake_pin6_set_o,
	// lock pin and its config field
	input  wire logic                      lock_control_pin_i,
	input  wire logic [1:0]                lock_pin_cfg_i,
	// unit activate bits and resulting enables
	input  wire logic                      floppy_act_i,
	input  wire logic                      midi_act_i,
	input  wire logic                      serial_act_i,
	input  wire logic                      parallel_act_i,
	output logic                           floppy_en_o,
	output logic                           midi_en_o,
	output logic                           serial_en_o,
	output logic                           parallel_en_o,
	// floppy write protect
	input  wire logic                      write_protect_n_i,
	input  wire logic                      drive_select0_n_i,
	input  wire logic                      drive_select1_n_i,
	input  wire logic                      force_wp_i,
	output logic                           floppy_wp_o,
	// first gpio pin
	input  wire logic                      gpio_pin_first_i,
	output logic                           gpio_pin_first_o,
	output logic                           gpio_pin_first_oe_o,
	input  wire logic                      gpio_out_val_i,
	output logic                           gpio_in_val_o,
	output logic                           joystick1_button1_o
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic        ack;       // bus answer
		logic [31:0] rdata;     // read word
		logic [7:0]  fifo_copy; // fcr copy
		logic [7:0]  edge_sel;  // edge modes
		logic [7:0]  force_off; // unit force off
		logic [7:0]  gpio_cfg;  // pin config
		logic [2:0]  kb2;       // sync s1,s2,prev
		logic [2:0]  kb6;       // sync s1,s2,prev
		logic [1:0]  lock;      // lock pin sync
		logic [1:0]  wp;        // wp pin sync
		logic [1:0]  gpin;      // gpio pin sync
		logic [3:0]  ev;        // set pulses
		logic [3:0]  en;        // unit enables
		logic        wp_out;    // write protect
		logic        g_out;     // pin data
		logic        g_oe;      // pin enable
		logic        g_in;      // pin value
		logic        joy;       // joystick btn
	} rmcr_state_t;

	rmcr_state_t s_q; // registered state
	rmcr_state_t s_d; // next state

	// address decode, used for read and write
	function automatic logic hit(input logic [rmcr_pkg::ADR_W-1:0] a,
	                             input logic [7:0] idx);
		hit = (a[rmcr_pkg::ADR_W-1:2] == idx);
	endfunction : hit

	logic       req;    // new bus request
	logic       wr;     // write commit edge
	logic       locked; // force-off locked
	logic       f2;     // pin2 fell
	logic       r2;     // pin2 rose
	logic       f6;     // pin6 fell
	logic       r6;     // pin6 rose
	logic       drv;    // gpio drives
	logic       oval;   // gpio out level
	logic [7:0] rd;     // read byte

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		// pin synchronisers, s1 feeds s2 only
		s_d.kb2  = {s_q.kb2[1], s_q.kb2[0], kbc_port1_bit2_i};
		s_d.kb6  = {s_q.kb6[1], s_q.kb6[0], kbc_port1_bit6_i};
		s_d.lock = {s_q.lock[0], lock_control_pin_i};
		s_d.wp   = {s_q.wp[0], write_protect_n_i};
		s_d.gpin = {s_q.gpin[0], gpio_pin_first_i};
		// edges from s2 against previous s2
		f2 = s_q.kb2[2] & ~s_q.kb2[1];
		r2 = ~s_q.kb2[2] & s_q.kb2[1];
		f6 = s_q.kb6[2] & ~s_q.kb6[1];
		r6 = ~s_q.kb6[2] & s_q.kb6[1];
		// falling always sets, rising only in both mode
		s_d.ev[0] = f2 | (r2 & s_q.edge_sel[rmcr_pkg::EB_P2_SYS]);
		s_d.ev[1] = f6 | (r6 & s_q.edge_sel[rmcr_pkg::EB_P6_SYS]);
		s_d.ev[2] = f2 | (r2 & s_q.edge_sel[rmcr_pkg::EB_P2_WAKE]);
		s_d.ev[3] = f6 | (r6 & s_q.edge_sel[rmcr_pkg::EB_P6_WAKE]);

		// bus: one wait state, ack drops after one cycle
		req       = cyc_i & stb_i & ~s_q.ack;
		s_d.ack   = req;
		wr        = cyc_i & stb_i & we_i & s_q.ack & sel_i[0];
		// lock armed when cfg is 01 and pin high
		locked    = (lock_pin_cfg_i == rmcr_pkg::LOCK_CFG_ARMED) & s_q.lock[1];

		// read mux, unmapped reads zero
		rd = 8'h00;
		if (hit(adr_i, rmcr_pkg::IDX_FIFO_COPY)) begin
			rd = s_q.fifo_copy;
		end else if (hit(adr_i, rmcr_pkg::IDX_EDGE)) begin
			rd = s_q.edge_sel;
		end else if (hit(adr_i, rmcr_pkg::IDX_FORCE_OFF)) begin
			rd = s_q.force_off;
		end else if (hit(adr_i, rmcr_pkg::IDX_GPIO_CFG)) begin
			rd = s_q.gpio_cfg;
		end
		s_d.rdata = req ? {24'h000000, rd} : 32'h00000000;

		// register writes, reserved bits stay zero
		if (wr && hit(adr_i, rmcr_pkg::IDX_EDGE)) begin
			s_d.edge_sel = dat_i[7:0] & rmcr_pkg::MASK_EDGE;
		end
		if (wr && !locked && hit(adr_i, rmcr_pkg::IDX_FORCE_OFF)) begin
			s_d.force_off = dat_i[7:0] & rmcr_pkg::MASK_FORCE_OFF;
		end
		if (wr && hit(adr_i, rmcr_pkg::IDX_GPIO_CFG)) begin
			s_d.gpio_cfg = dat_i[7:0] & rmcr_pkg::MASK_GPIO_CFG;
		end
		// copy follows serial port, bus writes ignored
		if (fcr_wr_i) begin
			s_d.fifo_copy = fcr_data_i & rmcr_pkg::MASK_FIFO_COPY;
		end

		// force-off overrides activate bits
		s_d.en[0] = floppy_act_i & ~s_q.force_off[rmcr_pkg::FB_FLOPPY];
		s_d.en[1] = midi_act_i & ~s_q.force_off[rmcr_pkg::FB_MIDI];
		s_d.en[2] = serial_act_i & ~s_q.force_off[rmcr_pkg::FB_SERIAL];
		s_d.en[3] = parallel_act_i & ~s_q.force_off[rmcr_pkg::FB_PAR];

		// write protect, active high
		s_d.wp_out = s_q.force_off[rmcr_pkg::FB_WP]
		           | ~s_q.wp[1]
		           | (~drive_select0_n_i & force_wp_i)
		           | (~drive_select1_n_i & force_wp_i);

		// gpio: polarity applies in both directions
		s_d.g_in = s_q.gpin[1] ^ s_q.gpio_cfg[rmcr_pkg::GB_POL];
		s_d.joy  = s_q.gpio_cfg[rmcr_pkg::GB_ALT] & s_d.g_in;
		// drive only as output in gpio function
		drv  = ~s_q.gpio_cfg[rmcr_pkg::GB_DIR] & ~s_q.gpio_cfg[rmcr_pkg::GB_ALT];
		oval = gpio_out_val_i ^ s_q.gpio_cfg[rmcr_pkg::GB_POL];
		if (s_q.gpio_cfg[rmcr_pkg::GB_OD]) begin
			// open drain: pull low only
			s_d.g_out = 1'b0;
			s_d.g_oe  = drv & ~oval;
		end else begin
			// push-pull
			s_d.g_out = oval;
			s_d.g_oe  = drv;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q           <= '0;
			s_q.fifo_copy <= rmcr_pkg::RST_FIFO_COPY;
			s_q.edge_sel  <= rmcr_pkg::RST_EDGE;
			s_q.force_off <= rmcr_pkg::RST_FORCE_OFF;
			s_q.gpio_cfg  <= rmcr_pkg::RST_GPIO_CFG;
			s_q.kb2       <= 3'h7;
			s_q.kb6       <= 3'h7;
			s_q.wp        <= 2'h3;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign dat_o               = s_q.rdata;
	assign ack_o               = s_q.ack;
	assign sysint_pin2_set_o   = s_q.ev[0];
	assign sysint_pin6_set_o   = s_q.ev[1];
	assign wake_pin2_set_o     = s_q.ev[2];
	assign wake_pin6_set_o     = s_q.ev[3];
	assign floppy_en_o         = s_q.en[0];
	assign midi_en_o           = s_q.en[1];
	assign serial_en_o         = s_q.en[2];
	assign parallel_en_o       = s_q.en[3];
	assign floppy_wp_o         = s_q.wp_out;
	assign gpio_pin_first_o    = s_q.g_out;
	assign gpio_pin_first_oe_o = s_q.g_oe;
	assign gpio_in_val_o       = s_q.g_in;
	assign joystick1_button1_o = s_q.joy;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	// copy takes fcr value on the next edge
	property p_copy_follow;
		@(posedge clk_i) disable iff (rst_i)
		fcr_wr_i |=> s_q.fifo_copy == ($past(fcr_data_i) & rmcr_pkg::MASK_FIFO_COPY);
	endproperty
	a_copy_follow: assert property (p_copy_follow) else $error("fifo copy missed update");

	// bus writes never touch the copy
	property p_copy_ro;
		@(posedge clk_i) disable iff (rst_i)
		!fcr_wr_i |=> $stable(s_q.fifo_copy);
	endproperty
	a_copy_ro: assert property (p_copy_ro) else $error("fifo copy changed by bus");

	// falling pin2 always sets sysint pulse
	property p_p2_fall;
		@(posedge clk_i) disable iff (rst_i)
		$fell(s_q.kb2[1]) |=> sysint_pin2_set_o;
	endproperty
	a_p2_fall: assert property (p_p2_fall) else $error("pin2 fall lost");

	// rising pin6 with both mode sets sysint
	property p_p6_both;
		@(posedge clk_i) disable iff (rst_i)
		($rose(s_q.kb6[1]) && s_q.edge_sel[rmcr_pkg::EB_P6_SYS]) |=> sysint_pin6_set_o;
	endproperty
	a_p6_both: assert property (p_p6_both) else $error("pin6 rise lost");

	// rising pin2 in fall mode leaves wake quiet
	property p_p2_wake_rise;
		@(posedge clk_i) disable iff (rst_i)
		($rose(s_q.kb2[1]) && !s_q.edge_sel[rmcr_pkg::EB_P2_WAKE]) |=> !wake_pin2_set_o;
	endproperty
	a_p2_wake_rise: assert property (p_p2_wake_rise) else $error("pin2 wake on rise");

	// pin6 wake pulse only after a pin6 edge
	property p_p6_wake_cause;
		@(posedge clk_i) disable iff (rst_i)
		wake_pin6_set_o |-> $past(s_q.kb6[2], 1) != $past(s_q.kb6[1], 1);
	endproperty
	a_p6_wake_cause: assert property (p_p6_wake_cause) else $error("pin6 wake no edge");

	// serial force-off keeps port disabled
	property p_serial_off;
		@(posedge clk_i) disable iff (rst_i)
		s_q.force_off[rmcr_pkg::FB_SERIAL] |=> !serial_en_o;
	endproperty
	a_serial_off: assert property (p_serial_off) else $error("serial not forced off");

	// parallel follows activate when not forced
	property p_par_follow;
		@(posedge clk_i) disable iff (rst_i)
		!s_q.force_off[rmcr_pkg::FB_PAR] |=> parallel_en_o == $past(parallel_act_i);
	endproperty
	a_par_follow: assert property (p_par_follow) else $error("parallel ignores activate");

	// forced write protect wins over pin
	property p_wp_force;
		@(posedge clk_i) disable iff (rst_i)
		s_q.force_off[rmcr_pkg::FB_WP] |=> floppy_wp_o;
	endproperty
	a_wp_force: assert property (p_wp_force) else $error("write protect not forced");

	// reserved force-off bits 2:1 stay zero
	property p_rsvd_zero;
		@(posedge clk_i) disable iff (rst_i)
		s_q.force_off[2:1] == 2'h0;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");

	// locked register ignores writes
	property p_locked;
		@(posedge clk_i) disable iff (rst_i)
		(wr && locked && hit(adr_i, rmcr_pkg::IDX_FORCE_OFF)) |=> $stable(s_q.force_off);
	endproperty
	a_locked: assert property (p_locked) else $error("locked register written");

	// input direction never drives the pin
	property p_gpio_in;
		@(posedge clk_i) disable iff (rst_i)
		s_q.gpio_cfg[rmcr_pkg::GB_DIR] |=> !gpio_pin_first_oe_o;
	endproperty
	a_gpio_in: assert property (p_gpio_in) else $error("input pin driven");

	// floppy force-off keeps controller disabled
	property p_floppy_off;
		@(posedge clk_i) disable iff (rst_i)
		s_q.force_off[rmcr_pkg::FB_FLOPPY] |=> !floppy_en_o;
	endproperty
	a_floppy_off: assert property (p_floppy_off) else $error("floppy not forced off");

	// midi force-off keeps unit disabled
	property p_midi_off;
		@(posedge clk_i) disable iff (rst_i)
		s_q.force_off[rmcr_pkg::FB_MIDI] |=> !midi_en_o;
	endproperty
	a_midi_off: assert property (p_midi_off) else $error("midi not forced off");

	// floppy follows activate when not forced
	property p_unit_follow;
		@(posedge clk_i) disable iff (rst_i)
		!s_q.force_off[rmcr_pkg::FB_FLOPPY] |=> floppy_en_o == $past(floppy_act_i);
	endproperty
	a_unit_follow: assert property (p_unit_follow) else $error("floppy ignores activate");

	// second drive select with forced bit protects
	property p_wp_ds1;
		@(posedge clk_i) disable iff (rst_i)
		(!drive_select1_n_i && force_wp_i) |=> floppy_wp_o;
	endproperty
	a_wp_ds1: assert property (p_wp_ds1) else $error("drive1 forced wp lost");

	// open drain never drives the pin high
	property p_od_low;
		@(posedge clk_i) disable iff (rst_i)
		s_q.gpio_cfg[rmcr_pkg::GB_OD] |=> !gpio_pin_first_o;
	endproperty
	a_od_low: assert property (p_od_low) else $error("open drain drives high");

	// joystick button quiet in gpio function
	property p_joy_off;
		@(posedge clk_i) disable iff (rst_i)
		!s_q.gpio_cfg[rmcr_pkg::GB_ALT] |=> !joystick1_button1_o;
	endproperty
	a_joy_off: assert property (p_joy_off) else $error("joystick active in gpio mode");

	// reserved edge-select bits stay zero
	property p_edge_rsvd;
		@(posedge clk_i) disable iff (rst_i)
		s_q.edge_sel[7:4] == 4'h0;
	endproperty
	a_edge_rsvd: assert property (p_edge_rsvd) else $error("edge reserved bits set");
endmodule : rmcr_top
`default_nettype wire

// ===== rtl/rmcr_pkg.sv
// Purpose: constants for the runtime misc config slice
// Assumes: one 32-bit wishbone word per register
// Notes:   byte address is four times the index
package rmcr_pkg;
	// ----------------------------------------
	// register indices (byte addr = idx * 4)
	// ----------------------------------------
	localparam int unsigned ADR_W = 10;
	localparam logic [7:0] IDX_FIFO_COPY = 8'h20;
	localparam logic [7:0] IDX_EDGE      = 8'h21;
	localparam logic [7:0] IDX_FORCE_OFF = 8'h22;
	localparam logic [7:0] IDX_GPIO_CFG  = 8'h23;
	// ----------------------------------------
	// reset values and writable masks
	// ----------------------------------------
	localparam logic [7:0] RST_FIFO_COPY  = 8'h00;
	localparam logic [7:0] RST_EDGE       = 8'h00;
	localparam logic [7:0] RST_FORCE_OFF  = 8'h00;
	localparam logic [7:0] RST_GPIO_CFG   = 8'h01;
	localparam logic [7:0] MASK_FIFO_COPY = 8'hcf;
	localparam logic [7:0] MASK_EDGE      = 8'h0f;
	localparam logic [7:0] MASK_FORCE_OFF = 8'he9;
	localparam logic [7:0] MASK_GPIO_CFG  = 8'h87;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int EB_P2_SYS  = 0;
	localparam int EB_P6_SYS  = 1;
	localparam int EB_P2_WAKE = 2;
	localparam int EB_P6_WAKE = 3;
	localparam int FB_WP      = 0;
	localparam int FB_FLOPPY  = 3;
	localparam int FB_MIDI    = 5;
	localparam int FB_SERIAL  = 6;
	localparam int FB_PAR     = 7;
	localparam int GB_DIR     = 0;
	localparam int GB_POL     = 1;
	localparam int GB_ALT     = 2;
	localparam int GB_OD      = 7;
	// lock pin config code that arms the lock
	localparam logic [1:0] LOCK_CFG_ARMED = 2'h1;
endpackage : rmcr_pkg

// ===== test/tb_top.sv
// Purpose: self-checking bench for the runtime misc config slice
// Assumes: classic wishbone, one 8-bit register per word, ack one cycle after request
// Notes:   pins pass two sync flops, so level checks wait a few cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, fcr_wr_i, lock_control_pin_i;
	logic [9:0]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, dat_o, rd_q;
	logic [7:0]  fcr_data_i;
	logic [1:0]  lock_pin_cfg_i;
	logic        ack_o, kbc_port1_bit2_i, kbc_port1_bit6_i, s2, s6, w2, w6;
	logic        floppy_act_i, midi_act_i, serial_act_i, parallel_act_i, fe, me, se, pe;
	logic        write_protect_n_i, drive_select0_n_i, drive_select1_n_i, force_wp_i, wp;
	logic        gpio_pin_first_i, gpio_out_val_i, g_out, g_oe, g_in, joy;
	int          n_errors, compares;
	// ----------------------------------------
	// device under test
	// ----------------------------------------
	rmcr_top u_rmcr_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.fcr_wr_i(fcr_wr_i), .fcr_data_i(fcr_data_i), .kbc_port1_bit2_i(kbc_port1_bit2_i),
		.kbc_port1_bit6_i(kbc_port1_bit6_i), .sysint_pin2_set_o(s2), .sysint_pin6_set_o(s6),
		.wake_pin2_set_o(w2), .wake_pin6_set_o(w6), .lock_control_pin_i(lock_control_pin_i),
		.lock_pin_cfg_i(lock_pin_cfg_i), .floppy_act_i(floppy_act_i), .midi_act_i(midi_act_i),
		.serial_act_i(serial_act_i), .parallel_act_i(parallel_act_i), .floppy_en_o(fe),
		.midi_en_o(me), .serial_en_o(se), .parallel_en_o(pe), .write_protect_n_i(write_protect_n_i),
		.drive_select0_n_i(drive_select0_n_i), .drive_select1_n_i(drive_select1_n_i),
		.force_wp_i(force_wp_i), .floppy_wp_o(wp), .gpio_pin_first_i(gpio_pin_first_i),
		.gpio_pin_first_o(g_out), .gpio_pin_first_oe_o(g_oe), .gpio_out_val_i(gpio_out_val_i),
		.gpio_in_val_o(g_in), .joystick1_button1_o(joy));
	// clock, 8 ns period
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic report_and_stop;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	// compare one value, count and report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	// one classic cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		n = 0;
		// look between edges, where ack and data are settled
		do begin
			@(negedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		rd_q = dat_o;
		chk({31'h0, ack_o}, 32'h1, "ack");
		// the edge that samples ack commits the transfer
		@(posedge clk_i);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
	endtask : wb
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		chk(rd_q, {24'h0, e}, "read");
	endtask : rd
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
	endtask : wait_n
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		rd(10'h080, 8'h00);
		rd(10'h084, 8'h00);
		rd(10'h088, 8'h00);
		rd(10'h08c, 8'h01);
		rd(10'h090, 8'h00);
	endtask : t_reset
	// copy follows the fifo control strobe, ignores the bus
	task automatic t_copy;
		@(posedge clk_i);
		fcr_wr_i   <= 1'b1;
		fcr_data_i <= 8'hff;
		@(posedge clk_i);
		fcr_data_i <= 8'h41;
		@(posedge clk_i);
		fcr_wr_i <= 1'b0;
		rd(10'h080, 8'h41);
		wb(1'b1, 10'h080, 8'hff);
		rd(10'h080, 8'h41);
		@(posedge clk_i);
		fcr_wr_i   <= 1'b1;
		fcr_data_i <= 8'hff;
		@(posedge clk_i);
		fcr_wr_i <= 1'b0;
		rd(10'h080, 8'hcf);
	endtask : t_copy
	// drive one pin to a level and count set pulses
	task automatic pin_edge(input int p6, input logic lvl, output int cs, output int cw);
		@(posedge clk_i);
		if (p6 != 0)
			kbc_port1_bit6_i <= lvl;
		else
			kbc_port1_bit2_i <= lvl;
		cs = 0;
		cw = 0;
		// count between edges; an unknown counts as a pulse
		repeat (10) begin
			@(negedge clk_i);
			cs += int'(((p6 != 0) ? s6 : s2) !== 1'b0);
			cw += int'(((p6 != 0) ? w6 : w2) !== 1'b0);
		end
	endtask : pin_edge
	task automatic t_edge;
		logic [7:0] m;
		int cs, cw;
		wb(1'b1, 10'h084, 8'hff);
		rd(10'h084, 8'h0f);
		for (int i = 0; i < 5; i++) begin
			m = (i == 4) ? 8'h00 : (8'h01 << i);
			wb(1'b1, 10'h084, m);
			for (int p = 0; p < 2; p++) begin
				pin_edge(p, 1'b0, cs, cw);
				chk(cs, 1, "sys fall");
				chk(cw, 1, "wake fall");
				pin_edge(p, 1'b1, cs, cw);
				chk(cs, m[p], "sys rise");
				chk(cw, m[p+2], "wake rise");
			end
		end
	endtask : t_edge
	// force-off bits, write protect terms
	task automatic t_force;
		logic [7:0] pos [4] = '{8'h08, 8'h20, 8'h40, 8'h80};
		wb(1'b1, 10'h088, 8'hff);
		rd(10'h088, 8'he9);
		wait_n(4);
		chk({fe, me, se, pe, wp}, 5'b00001, "all off");
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, 10'h088, pos[i]);
			wait_n(4);
			chk({fe, me, se, pe}, 4'hf ^ (4'h8 >> i), "one off");
		end
		wb(1'b1, 10'h088, 8'h00);
		wait_n(4);
		chk({fe, me, se, pe, wp}, 5'b11110, "all on");
		write_protect_n_i <= 1'b0;
		wait_n(6);
		chk(wp, 1'b1, "wp pin");
		write_protect_n_i <= 1'b1;
		force_wp_i        <= 1'b1;
		drive_select0_n_i <= 1'b0;
		wait_n(6);
		chk(wp, 1'b1, "forced wp");
		force_wp_i <= 1'b0;
		wait_n(4);
		chk(wp, 1'b0, "no wp");
		drive_select0_n_i <= 1'b1;
		drive_select1_n_i <= 1'b0;
		force_wp_i        <= 1'b1;
		wait_n(4);
		chk(wp, 1'b1, "forced wp drive1");
		{drive_select1_n_i, force_wp_i} <= 2'b10;
		{floppy_act_i, midi_act_i, serial_act_i, parallel_act_i} <= 4'h0;
		wait_n(4);
		chk({fe, me, se, pe, wp}, 5'b00000, "activate off");
		{floppy_act_i, midi_act_i, serial_act_i, parallel_act_i} <= 4'hf;
	endtask : t_force
	// lock pin makes the force-off register read-only
	task automatic t_lock;
		lock_pin_cfg_i     <= 2'h1;
		lock_control_pin_i <= 1'b1;
		wait_n(5);
		wb(1'b1, 10'h088, 8'h08);
		rd(10'h088, 8'h00);
		lock_control_pin_i <= 1'b0;
		wait_n(5);
		wb(1'b1, 10'h088, 8'h08);
		rd(10'h088, 8'h08);
		lock_pin_cfg_i     <= 2'h2;
		lock_control_pin_i <= 1'b1;
		wait_n(5);
		wb(1'b1, 10'h088, 8'h00);
		rd(10'h088, 8'h00);
	endtask : t_lock
	// gpio direction, polarity, function and driver type
	task automatic t_gpio;
		logic [7:0] cfg [9] = '{8'h00, 8'h02, 8'h80, 8'h82, 8'h01, 8'h03, 8'h05, 8'h07, 8'hff};
		logic x, drv;
		for (int i = 0; i < 9; i++) begin
			wb(1'b1, 10'h08c, cfg[i]);
			rd(10'h08c, cfg[i] & 8'h87);
			for (int v = 0; v < 2; v++) begin
				gpio_out_val_i   <= v[0];
				gpio_pin_first_i <= v[0];
				wait_n(6);
				x   = v[0] ^ cfg[i][1];
				drv = !cfg[i][0] && !cfg[i][2];
				chk(g_oe, drv && (!cfg[i][7] || !x), "oe");
				if (drv)
					chk(g_out, x && !cfg[i][7], "out");
				else if (!cfg[i][2])
					chk(g_in, x, "in");
				chk(joy, cfg[i][2] && x, "joy");
			end
		end
	endtask : t_gpio
	// reset in mid-run brings registers and outputs back
	task automatic t_rerst;
		@(posedge clk_i);
		rst_i <= 1'b1;
		wait_n(3);
		rst_i <= 1'b0;
		t_reset();
		chk({fe, me, se, pe, wp, g_oe}, 6'b111100, "outputs after reset");
	endtask : t_rerst
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		n_errors = 0;
		compares = 0;
		{rst_i, cyc_i, stb_i, we_i, fcr_wr_i, force_wp_i, lock_control_pin_i} = 7'h40;
		{adr_i, dat_i, fcr_data_i, lock_pin_cfg_i} = '0;
		sel_i = 4'hf;
		{kbc_port1_bit2_i, kbc_port1_bit6_i, write_protect_n_i} = 3'h7;
		{drive_select0_n_i, drive_select1_n_i} = 2'h3;
		{floppy_act_i, midi_act_i, serial_act_i, parallel_act_i} = 4'hf;
		{gpio_pin_first_i, gpio_out_val_i} = 2'h0;
		wait_n(12);
		rst_i <= 1'b0;
		t_reset();
		t_copy();
		t_edge();
		t_force();
		t_lock();
		t_gpio();
		t_rerst();
		report_and_stop();
	end
	initial begin
		wait_n(20000);
		n_errors++;
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
